//--- verification/otp_link_properties.sv
// Link checker for the two-wire potentiometer port
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"

module otp_link_properties (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  // Link
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_s_oe,
  // Device side
  input wire logic       address_select_bit,
  input wire logic [5:0] wiper_register,
  input wire logic       validation_status_high,
  input wire logic       validation_status_low,
  input wire logic       prog_busy
);
  // ------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------
  logic       scl_q, scl_d, sda_q, sda_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] rd_byte;
  logic       start, stop, rise, match, rd_bit;

  always_comb begin
    start = scl_in && scl_q && sda_q && !sda_in;
    stop = scl_in && scl_q && !sda_q && sda_in;
    rise = scl_in && !scl_q;
    match = addr_q[7:2] == `OTP_ADDR_PREFIX && addr_q[1] == address_select_bit;
    rd_byte = {validation_status_high, validation_status_low, wiper_register};
    rd_bit = rd_byte[3'(5'h10 - cnt_q)];
    scl_d = scl_in;
    sda_d = sda_in;
    cnt_d = start ? 5'h00 : (rise && cnt_q != 5'h1f) ? cnt_q + 5'h01 : cnt_q;
    addr_d = (rise && cnt_q < 5'h08) ? {addr_q[6:0], sda_in} : addr_q;
  end

  // Count starts saturated so no count-based check fires before the first start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 5'h1f;
      addr_q <= 8'h00;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_quiet;
    !sda_s_oe [*8];
  endsequence

  sequence s_clocking;
    ##[1:40] !scl_in;
  endsequence

  reset_mid_a: assert property ($rose(arst_n) |-> wiper_register == `OTP_WIPER_MID)
    else $error("wiper not midscale after reset");
  start_clock_a: assert property (start |-> s_clocking)
    else $error("no clock after start");
  addr_silent_a: assert property (rise && cnt_q < 5'h08 |-> !sda_s_oe)
    else $error("device drives during address");
  addr_ack_a: assert property (rise && cnt_q == 5'h08 |-> sda_s_oe == match)
    else $error("address acknowledge wrong");
  write_ack_a: assert property (rise && (cnt_q == 5'h11 || cnt_q == 5'h1a) && match
    && !addr_q[0] |-> sda_s_oe) else $error("write byte not acknowledged");
  read_data_a: assert property (rise && cnt_q inside {[5'h09:5'h10]} && match
    && addr_q[0] |-> sda_in == rd_bit) else $error("read bit wrong");
  read_nack_a: assert property (rise && cnt_q == 5'h11 && match && addr_q[0]
    |-> !sda_s_oe && sda_in) else $error("read byte acknowledged");
  dev_change_a: assert property ($changed(sda_s_oe) |-> !scl_in)
    else $error("device moved data while clock high");
  stop_quiet_a: assert property (stop |=> s_quiet)
    else $error("device drives after stop");
  lock_hold_a: assert property (validation_status_high && validation_status_low
    && !prog_busy |=> $stable(wiper_register)) else $error("locked wiper moved");
endmodule // otp_link_properties

`default_nettype wire

//--- verification/otp_pot_twowire_slave_port_test.sv
// Self-checking bench joining the master end and the potentiometer end
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp); end end

module otp_pot_twowire_slave_port_test;
  logic        core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [1:0]  avs_address, stm;
  logic [31:0] avs_writedata, avs_readdata, st;
  logic        address_select_bit, test_fuse_ok, pin, sel;
  logic        validation_status_high, validation_status_low, prog_busy;
  logic [5:0]  data_fuse_ok, wiper_register, wm;
  logic [7:0]  dat;
  int          errors, checks_done, seed;

  otp_link_if otp_link_if_inst ();
  otp_bus_master otp_bus_master_inst (.core_clk(core_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(otp_link_if_inst.master));
  otp_pot_slave otp_pot_slave_inst (.core_clk(core_clk), .arst_n(arst_n),
    .link(otp_link_if_inst.device), .address_select_bit(address_select_bit),
    .test_fuse_ok(test_fuse_ok), .data_fuse_ok(data_fuse_ok),
    .wiper_register(wiper_register), .validation_status_high(validation_status_high),
    .validation_status_low(validation_status_low), .prog_busy(prog_busy));
  otp_link_properties otp_link_properties_inst (.core_clk(core_clk), .arst_n(arst_n),
    .scl_in(otp_link_if_inst.scl_in), .sda_in(otp_link_if_inst.sda_in),
    .sda_s_oe(otp_link_if_inst.sda_s_oe), .address_select_bit(address_select_bit),
    .wiper_register(wiper_register), .validation_status_high(validation_status_high),
    .validation_status_low(validation_status_low), .prog_busy(prog_busy));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [7:0] exp_read(input logic [1:0] s, input logic [5:0] w);
    return {s, w};
  endfunction

  function automatic logic [1:0] prog_status(input logic tf, input logic [5:0] df);
    if (!tf) return `OTP_ST_TEST_FAIL;
    return (df != 6'h3f) ? `OTP_ST_FATAL : `OTP_ST_DONE;
  endfunction

  task automatic final_report;
    $display("errors %0d, checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Busy is polled; the fuse sequence may outlast the link transfer
  task automatic xfer(input logic rd, input logic s, input logic [7:0] ins,
                      input logic [7:0] d);
    logic [31:0] q;
    if (!rd) begin
      bus(1'b1, 2'h1, {24'h0, ins}, q);
      bus(1'b1, 2'h2, {24'h0, d}, q);
    end
    bus(1'b1, 2'h0, {29'h0, 1'b1, rd, s}, q);
    do begin
      bus(1'b0, 2'h3, 32'h0, st);
    end while (st[8] !== 1'b0);
    while (prog_busy !== 1'b0) begin
      @(posedge core_clk);
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 32'h06efdbea;
    errors = 0;
    checks_done = 0;
    arst_n = 1'b0;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    address_select_bit = 1'b0;
    test_fuse_ok = 1'b1;
    data_fuse_ok = 6'h3f;
    wm = `OTP_WIPER_MID;
    stm = `OTP_ST_READY;
    pin = 1'b0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    `CHK(wiper_register, wm)
    xfer(1'b1, pin, 8'h00, 8'h00);
    `CHK(st[9:0], {2'b00, exp_read(stm, wm)})
    // Random strap and select, one mismatched pass
    for (int i = 0; i < 8; i++) begin
      pin = 1'($random(seed));
      sel = (i == 3) ? !pin : pin;
      dat = 8'($random(seed));
      address_select_bit <= pin;
      xfer(1'b0, sel, 8'($random(seed)) & 8'h7f, dat);
      if (sel == pin) wm = dat[5:0];
      `CHK(st[9], sel != pin)
      `CHK(wiper_register, wm)
      xfer(1'b1, sel, 8'h00, 8'h00);
      `CHK(st[9], sel != pin)
      if (sel == pin) `CHK(st[7:0], exp_read(stm, wm))
    end
    // Test fuse fail, fatal mismatch, then success
    for (int i = 0; i < 3; i++) begin
      test_fuse_ok <= (i != 0);
      data_fuse_ok <= (i == 1) ? 6'h00 : 6'h3f;
      dat = 8'($random(seed)) | 8'h01;
      xfer(1'b0, pin, 8'($random(seed)) | 8'h80, dat);
      wm = dat[5:0];
      stm = prog_status(i != 0, (i == 1) ? 6'h00 : 6'h3f);
      `CHK({validation_status_high, validation_status_low}, stm)
      xfer(1'b1, pin, 8'h00, 8'h00);
      `CHK(st[7:0], exp_read(stm, wm))
    end
    xfer(1'b0, pin, 8'h00, {2'b11, ~wm});
    `CHK(wiper_register, wm)
    xfer(1'b1, pin, 8'h00, 8'h00);
    `CHK(st[9:0], {2'b00, exp_read(`OTP_ST_DONE, wm)})
    final_report;
  end

  // Roughly three and a half times the expected run length
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    final_report;
  end
endmodule // otp_pot_twowire_slave_port_test

`default_nettype wire

//--- verilog/otp_bus_master.sv
// Master end: Avalon-MM command registers driving a two-wire transfer
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"

module otp_bus_master (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic  [1:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Link
  otp_link_if.master       link
);

  // ----------------------------------------------------------------
  // Registers: 0 ctrl {go,read,sel}, 1 instr, 2 data, 3 status
  // ----------------------------------------------------------------
  logic       rd_q, sel_q, busy_q;
  logic [7:0] instr_q, data_q, rdata_q;
  logic       nack_q;
  logic [31:0] rdo_q;
  logic        wait_q;
  logic        go;

  assign go = avs_write && !wait_q && avs_address == 2'h0 && avs_writedata[2] && !busy_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 1'b0; sel_q <= 1'b0; instr_q <= 8'h00; data_q <= 8'h00;
      rdo_q <= 32'h0; wait_q <= 1'b1;
    end else begin
      wait_q <= !(avs_read || avs_write) || !wait_q;
      if (avs_write && !wait_q) begin
        case (avs_address)
          2'h0: begin rd_q <= avs_writedata[1]; sel_q <= avs_writedata[0]; end
          2'h1: instr_q <= avs_writedata[7:0];
          2'h2: data_q <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (avs_read && wait_q) begin
        rdo_q <= (avs_address == 2'h3) ? {22'h0, nack_q, busy_q, rdata_q} :
                 (avs_address == 2'h1) ? {24'h0, instr_q} :
                 (avs_address == 2'h2) ? {24'h0, data_q} :
                 {29'h0, 1'b0, rd_q, sel_q};
      end
    end
  end
  assign avs_readdata    = rdo_q;
  assign avs_waitrequest = wait_q;

  // ----------------------------------------------------------------
  // Bit engine: phase 0..3 per bit, one phase per divider tick
  // ----------------------------------------------------------------
  otp_pkg::otp_master_state_type st_q, st_d;
  logic [7:0] div_q;
  logic       tick;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic [7:0] sh_q, sh_d, rdata_d;
  logic       scl_q, scl_d, sda_q, sda_d, busy_d, nack_d;
  logic       sda_s1, sda_s2;

  assign tick = (div_q == `OTP_SCL_HALF);

  always_comb begin
    st_d = st_q; ph_d = ph_q; bit_d = bit_q; byte_d = byte_q; sh_d = sh_q;
    scl_d = scl_q; sda_d = sda_q; busy_d = busy_q; rdata_d = rdata_q; nack_d = nack_q;
    if (go) begin
      st_d = otp_pkg::OTP_MS_START; ph_d = 2'h0; busy_d = 1'b1; nack_d = 1'b0;
    end else if (tick) begin
      ph_d = ph_q + 2'h1;
      case (st_q)
        otp_pkg::OTP_MS_START: begin
          if (ph_q == 2'h1) sda_d = 1'b0;
          if (ph_q == 2'h3) begin
            scl_d = 1'b0; st_d = otp_pkg::OTP_MS_BIT; bit_d = 4'h0; byte_d = 2'h0;
            sh_d = {`OTP_ADDR_PREFIX, sel_q, rd_q};
          end
        end
        otp_pkg::OTP_MS_BIT: begin
          case (ph_q)
            2'h0: begin
              if (bit_q < 4'h8) sda_d = (byte_q == 2'h0 || !rd_q) ? sh_q[7] : 1'b1;
              else sda_d = 1'b1;
            end
            2'h1: scl_d = 1'b1;
            2'h2: begin
              if (bit_q < 4'h8) rdata_d = {rdata_q[6:0], sda_s2};
              else if (sda_s2) nack_d = (byte_q == 2'h0 || !rd_q) ? 1'b1 : nack_q;
            end
            default: begin
              scl_d = 1'b0; sh_d = {sh_q[6:0], 1'b0}; bit_d = bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_d = 4'h0; byte_d = byte_q + 2'h1;
                sh_d = (byte_q == 2'h0) ? instr_q : data_q;
                if (nack_q || (rd_q && byte_q == 2'h1) || byte_q == 2'h2) begin
                  st_d = otp_pkg::OTP_MS_STOP;
                end
              end
            end
          endcase
        end
        otp_pkg::OTP_MS_STOP: begin
          if (ph_q == 2'h0) sda_d = 1'b0;
          if (ph_q == 2'h1) scl_d = 1'b1;
          if (ph_q == 2'h2) sda_d = 1'b1;
          if (ph_q == 2'h3) st_d = otp_pkg::OTP_MS_DONE;
        end
        otp_pkg::OTP_MS_DONE: begin busy_d = 1'b0; st_d = otp_pkg::OTP_MS_IDLE; end
        default: ph_d = 2'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= otp_pkg::OTP_MS_IDLE; div_q <= 8'h00; ph_q <= 2'h0; bit_q <= 4'h0;
      byte_q <= 2'h0; sh_q <= 8'h00; scl_q <= 1'b1; sda_q <= 1'b1; busy_q <= 1'b0;
      rdata_q <= 8'h00; nack_q <= 1'b0; sda_s1 <= 1'b1; sda_s2 <= 1'b1;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      st_q <= st_d; ph_q <= ph_d; bit_q <= bit_d; byte_q <= byte_d; sh_q <= sh_d;
      scl_q <= scl_d; sda_q <= sda_d; busy_q <= busy_d; rdata_q <= rdata_d; nack_q <= nack_d;
      sda_s1 <= link.sda_in; sda_s2 <= sda_s1;
    end
  end

  assign link.scl_out   = 1'b0;
  assign link.scl_oe    = !scl_q;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe  = !sda_q;

endmodule // otp_bus_master

`default_nettype wire

//--- verilog/otp_defines.svh
// Constants for the one-time-programmable potentiometer two-wire port
`ifndef OTP_DEFINES_SVH
`define OTP_DEFINES_SVH

`define OTP_ADDR_PREFIX    6'h16
`define OTP_WIPER_MID      6'h20
`define OTP_PROG_BIT       7
`define OTP_ST_READY       2'h0
`define OTP_ST_TEST_FAIL   2'h1
`define OTP_ST_FATAL       2'h2
`define OTP_ST_DONE        2'h3
`define OTP_FUSE_STEPS     3'h6
`define OTP_SCL_HALF       8'h06

`endif

//--- verilog/otp_fuse_seq.sv
// Fuse programming sequencer: test fuse, six data fuses, then compare setting DONE or FATAL
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"

module otp_fuse_seq (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Request
  input  wire logic       prog_start,
  input  wire logic [5:0] wiper_code,
  // Fuse model results
  input  wire logic       test_fuse_ok,
  input  wire logic [5:0] data_fuse_ok,
  // Status
  output logic      [1:0] status,
  output logic            busy
);

  otp_pkg::otp_fuse_state_type state_q, state_d;
  logic [2:0] step_q, step_d;
  logic [5:0] fuses_q, fuses_d;
  logic [1:0] status_q, status_d;

  always_comb begin
    state_d  = state_q;
    step_d   = step_q;
    fuses_d  = fuses_q;
    status_d = status_q;
    case (state_q)
      otp_pkg::OTP_FU_IDLE: begin
        if (prog_start && status_q != `OTP_ST_DONE) begin
          state_d = otp_pkg::OTP_FU_TEST;
        end
      end
      otp_pkg::OTP_FU_TEST: begin
        if (test_fuse_ok) begin
          state_d = otp_pkg::OTP_FU_DATA;
          step_d  = 3'h0;
          fuses_d = 6'h00;
        end else begin
          status_d = `OTP_ST_TEST_FAIL;
          state_d  = otp_pkg::OTP_FU_IDLE;
        end
      end
      otp_pkg::OTP_FU_DATA: begin
        // One data fuse per internal cycle
        fuses_d[step_q] = wiper_code[step_q] & data_fuse_ok[step_q];
        step_d = step_q + 3'h1;
        if (step_q == `OTP_FUSE_STEPS - 3'h1) begin
          state_d = otp_pkg::OTP_FU_CHECK;
        end
      end
      otp_pkg::OTP_FU_CHECK: begin
        status_d = (fuses_q == wiper_code) ? `OTP_ST_DONE : `OTP_ST_FATAL;
        state_d  = otp_pkg::OTP_FU_IDLE;
      end
      default: state_d = otp_pkg::OTP_FU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= otp_pkg::OTP_FU_IDLE;
      step_q   <= 3'h0;
      fuses_q  <= 6'h00;
      status_q <= `OTP_ST_READY;
    end else begin
      state_q  <= state_d;
      step_q   <= step_d;
      fuses_q  <= fuses_d;
      status_q <= status_d;
    end
  end

  assign status = status_q;
  assign busy   = (state_q != otp_pkg::OTP_FU_IDLE);

endmodule // otp_fuse_seq

`default_nettype wire

//--- verilog/otp_link_if.sv
// Two-wire link joining the master end and the potentiometer end
`timescale 1ns/1ps
`default_nettype none

interface otp_link_if;
  logic scl_out;
  logic scl_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  wire  scl_in;
  wire  sda_in;

  // Open-drain with pull-ups: low wins whenever any driver is enabled low
  assign scl_in = !(scl_oe && !scl_out);
  assign sda_in = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));

  modport master (
    output scl_out, scl_oe, sda_m_out, sda_m_oe,
    input  scl_in, sda_in
  );

  modport device (
    output sda_s_out, sda_s_oe,
    input  scl_in, sda_in
  );
endinterface

`default_nettype wire

//--- verilog/otp_pkg.sv
// Types shared by both ends of the two-wire potentiometer link
package otp_pkg;

  typedef enum logic [2:0] {
    OTP_SL_IDLE = 3'b000,
    OTP_SL_ADDR = 3'b001,
    OTP_SL_INSTR = 3'b010,
    OTP_SL_WDATA = 3'b011,
    OTP_SL_RDATA = 3'b100,
    OTP_SL_WAIT = 3'b101
  } otp_slave_state_type;

  typedef enum logic [2:0] {
    OTP_MS_IDLE  = 3'b000,
    OTP_MS_START = 3'b001,
    OTP_MS_BIT   = 3'b010,
    OTP_MS_STOP  = 3'b011,
    OTP_MS_DONE  = 3'b100
  } otp_master_state_type;

  typedef enum logic [1:0] {
    OTP_FU_IDLE = 2'b00,
    OTP_FU_TEST = 2'b01,
    OTP_FU_DATA = 2'b10,
    OTP_FU_CHECK = 2'b11
  } otp_fuse_state_type;

endpackage

//--- verilog/otp_pot_slave.sv
// Potentiometer end: two-wire slave, wiper register and fuse control
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"

module otp_pot_slave (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Link
  otp_link_if.device      link,
  // Strap and fuse model
  input  wire logic       address_select_bit,
  input  wire logic       test_fuse_ok,
  input  wire logic [5:0] data_fuse_ok,
  // Wiper and status
  output logic      [5:0] wiper_register,
  output logic            validation_status_high,
  output logic            validation_status_low,
  output logic            prog_busy
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_q, sda_sync_q, asel_sync_q;
  logic       scl_q, sda_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      asel_sync_q <= 2'h0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], link.scl_in};
      sda_sync_q <= {sda_sync_q[0], link.sda_in};
      // Strap pin is asynchronous to the core clock
      asel_sync_q <= {asel_sync_q[0], address_select_bit};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_s    = scl_sync_q[1];
  assign sda_s    = sda_sync_q[1];
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_ev = scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev  = scl_s && scl_q && !sda_q && sda_s;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  otp_pkg::otp_slave_state_type state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic       prog_q, prog_d;
  logic [5:0] wiper_q, wiper_d;
  logic       sda_oe_q, sda_oe_d;
  logic       ack_q, ack_d;
  logic       pstart_q, pstart_d;
  logic [1:0] status;
  logic       busy;

  otp_fuse_seq u_fuse (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .prog_start   (pstart_q),
    .wiper_code   (wiper_q),
    .test_fuse_ok (test_fuse_ok),
    .data_fuse_ok (data_fuse_ok),
    .status       (status),
    .busy         (busy)
  );

  logic locked;
  assign locked = (status == `OTP_ST_DONE) || busy;

  always_comb begin
    state_d  = state_q;
    bit_d    = bit_q;
    shift_d  = shift_q;
    prog_d   = prog_q;
    wiper_d  = wiper_q;
    sda_oe_d = sda_oe_q;
    ack_d    = ack_q;
    pstart_d = 1'b0;
    if (start_ev) begin
      state_d  = otp_pkg::OTP_SL_ADDR;
      bit_d    = 4'h0;
      sda_oe_d = 1'b0;
      ack_d    = 1'b0;
    end else if (stop_ev) begin
      state_d  = otp_pkg::OTP_SL_IDLE;
      sda_oe_d = 1'b0;
      ack_d    = 1'b0;
    end else if (state_q != otp_pkg::OTP_SL_IDLE && state_q != otp_pkg::OTP_SL_WAIT) begin
      if (scl_rise && !ack_q && bit_q < 4'h8) begin
        shift_d = {shift_q[6:0], sda_s};
        bit_d   = bit_q + 4'h1;
      end else if (scl_rise) begin
        bit_d = 4'h9;
      end else if (scl_fall) begin
        // Drive only on falling edges, so the line is stable while high
        if (bit_q == 4'h8 && !ack_q) begin
          ack_d = 1'b1;
          case (state_q)
            otp_pkg::OTP_SL_ADDR: begin
              if (shift_q[7:2] == `OTP_ADDR_PREFIX &&
                  shift_q[1] == asel_sync_q[1]) begin
                sda_oe_d = 1'b1;
              end else begin
                state_d = otp_pkg::OTP_SL_WAIT;
              end
            end
            otp_pkg::OTP_SL_INSTR: begin
              prog_d   = shift_q[`OTP_PROG_BIT];
              sda_oe_d = 1'b1;
            end
            otp_pkg::OTP_SL_WDATA: begin
              sda_oe_d = 1'b1;
              if (!locked) begin
                wiper_d = shift_q[5:0];
                pstart_d = prog_q;
              end
            end
            otp_pkg::OTP_SL_RDATA: begin
              sda_oe_d = 1'b0;
              state_d  = otp_pkg::OTP_SL_WAIT;
            end
            default: state_d = otp_pkg::OTP_SL_WAIT;
          endcase
        end else if (bit_q == 4'h9) begin
          // Ack clock finished: move to next byte
          ack_d    = 1'b0;
          bit_d    = 4'h0;
          sda_oe_d = 1'b0;
          case (state_q)
            otp_pkg::OTP_SL_ADDR: begin
              if (shift_q[0]) begin
                state_d  = otp_pkg::OTP_SL_RDATA;
                shift_d  = {status, wiper_q};
                sda_oe_d = !status[1];
              end else begin
                state_d = otp_pkg::OTP_SL_INSTR;
              end
            end
            otp_pkg::OTP_SL_INSTR: state_d = otp_pkg::OTP_SL_WDATA;
            otp_pkg::OTP_SL_WDATA: state_d = otp_pkg::OTP_SL_WDATA;
            default:               state_d = otp_pkg::OTP_SL_WAIT;
          endcase
        end else if (state_q == otp_pkg::OTP_SL_RDATA && bit_q < 4'h8) begin
          // Rising edge already shifted, so the next bit sits at the top
          sda_oe_d = !shift_q[7];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= otp_pkg::OTP_SL_IDLE;
      bit_q    <= 4'h0;
      shift_q  <= 8'h00;
      prog_q   <= 1'b0;
      wiper_q  <= `OTP_WIPER_MID;
      sda_oe_q <= 1'b0;
      ack_q    <= 1'b0;
      pstart_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      bit_q    <= bit_d;
      shift_q  <= shift_d;
      prog_q   <= prog_d;
      wiper_q  <= wiper_d;
      sda_oe_q <= sda_oe_d;
      ack_q    <= ack_d;
      pstart_q <= pstart_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [1:0] stat_out_q;
  logic       busy_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_out_q <= `OTP_ST_READY;
      busy_q     <= 1'b0;
    end else begin
      stat_out_q <= status;
      busy_q     <= busy;
    end
  end

  assign link.sda_s_out         = 1'b0;
  assign link.sda_s_oe          = sda_oe_q;
  assign wiper_register         = wiper_q;
  assign validation_status_high = stat_out_q[1];
  assign validation_status_low  = stat_out_q[0];
  assign prog_busy              = busy_q;

endmodule // otp_pot_slave

`default_nettype wire
